// [tfg_pkg.sv]
// Purpose: Shared constants and types for the tone frequency generator and buzzer block
// Assumes: 20 MHz system clock, 32-bit AHB-Lite register access
// Notes:   Register offsets are byte addresses, one aligned word each
package tfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLOCK_HZ       = 20000000;
    localparam int PH0_HZ         = 32768;
    // Tap counter steps at twice the tap-zero rate so that bit n is tap n
    localparam int PH_TICK_CYCLES = CLOCK_HZ / (2 * PH0_HZ);
    localparam int TAP_COUNT      = 16;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] ADDR_CLK_SRC    = 8'h00;
    localparam logic [7:0] ADDR_PRESET_REG = 8'h04;
    localparam logic [7:0] ADDR_PRESET_IDX = 8'h08;
    localparam logic [7:0] ADDR_PRESET_IMM = 8'h0c;
    localparam logic [7:0] ADDR_BUZ_MIX    = 8'h10;
    localparam logic [7:0] ADDR_PIN_CFG    = 8'h14;
    localparam logic [7:0] ADDR_STATUS     = 8'h18;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DUTY_LSB     = 8;
    localparam int ACC_LSB      = 4;
    localparam int ENV_LSB      = 3;
    localparam int ENV_TAP_BASE = 10;
    localparam int ST_RUN_BIT   = 10;
    localparam int ST_GOUT_BIT  = 11;
    localparam int ST_BZ_BIT    = 12;
    localparam int ST_PEND_BIT  = 13;

    ////////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [1:0] {
        SRC_PH0  = 2'b00,
        SRC_PH1  = 2'b01,
        SRC_PH2  = 2'b10,
        SRC_BASE = 2'b11
    } tfg_src_type;

    typedef enum logic [1:0] {
        DUTY_QUARTER = 2'b00,
        DUTY_THIRD   = 2'b01,
        DUTY_HALF    = 2'b10,
        DUTY_FULL    = 2'b11
    } tfg_duty_type;

    typedef enum logic [2:0] {
        CAR_OFF  = 3'b000,
        CAR_PH3  = 3'b001,
        CAR_PH4  = 3'b010,
        CAR_PH5  = 3'b011,
        CAR_GENERATOR_OUTPUT = 3'b100
    } tfg_carrier_type;

    typedef enum logic [0:0] {
        GEN_IDLE = 1'b0,
        GEN_RUN  = 1'b1
    } tfg_gen_type;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam tfg_src_type  RST_SRC  = SRC_PH0;
    localparam tfg_duty_type RST_DUTY = DUTY_QUARTER;
    localparam logic [7:0]   RST_N    = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // State carriers
    typedef struct packed {
        logic [8:0]  div;
        logic [15:0] cnt;
    } tfg_prediv_state_type;

    typedef struct packed {
        logic            a_valid;
        logic            a_write;
        logic [7:0]      a_addr;
        logic [31:0]     hrdata;
        logic            hreadyout;
        tfg_src_type     src;
        logic            pin_sel;
        tfg_carrier_type carrier;
        logic [5:0]      env;
        tfg_gen_type     gen_state;
        logic [7:0]      n_act;
        tfg_duty_type    duty_act;
        logic [7:0]      n_pend;
        tfg_duty_type    duty_pend;
        logic            pend_valid;
        logic [7:0]      dcnt;
        logic [1:0]      phase;
        logic            gout;
        logic            gtick;
        logic            idx_wait;
        logic [7:0]      idx_ptr;
        tfg_duty_type    idx_duty;
        logic            bz_t;
        logic            bz_i;
        logic            pin_b3;
        logic            pin_b4;
    } tfg_top_state_type;

endpackage : tfg_pkg

// [tfg_prediv.sv]
// Purpose: Pre-divider producing tap levels and one-cycle rising-edge enables
// Assumes: Runs on the single system clock, synchronous-released reset
// Notes:   Tap rates are approximate since 20 MHz is not a power-of-two multiple
`timescale 1ns/1ps
module tfg_prediv
    import tfg_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Taps
    output logic [TAP_COUNT-1:0]      tap_level,
    output logic [TAP_COUNT-1:0]      tap_rise
);

    tfg_prediv_state_type st;
    tfg_prediv_state_type nx;
    logic                 tick;

    ////////////////////////////////////////////////////////////////////////////
    // Base tick divider and tap counter
    assign tick = (st.div == 9'(PH_TICK_CYCLES - 1));

    always_comb
    begin
        nx = st;
        if (tick)
        begin
            nx.div = 9'h000;
            nx.cnt = st.cnt + 16'h0001;
        end
        else
        begin
            nx.div = st.div + 9'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= nx;
    end

    assign tap_level = st.cnt;

    ////////////////////////////////////////////////////////////////////////////
    // A tap rises when all lower bits are set and it is still low
    assign tap_rise[0] = tick & ~st.cnt[0];

    genvar g;
    generate
        for (g = 1; g < TAP_COUNT; g++)
        begin : g_rise
            assign tap_rise[g] = tick & (&st.cnt[g-1:0]) & ~st.cnt[g];
        end
    endgenerate

endmodule : tfg_prediv

// [tfg_top.sv]
// Functional notes
// (RULE1) Output frequency is source over (N+1) times X
// (RULE2) Duty code 00 quarter, 01 third, 10 half, 11 full
// (RULE3) Register form: upper nibble accumulator, lower memory
// (RULE4) Indexed form loads all bits from table
// (RULE5) Immediate form loads all bits from operand
// (RULE6) Source select chooses the divider's clock input
// (RULE7) Preset loads scaling and duty, then starts
// (RULE8) Generator output offered as clock to others
// (RULE9) Buzzer pins are complementary while active
// (RULE10) Configuration puts buzzer on port B pins
// (RULE11) Carrier is one of three taps or generator
// (RULE12) Envelope is any combination of taps ten-fifteen
// (RULE13) Mix write sets carrier and envelope taps
// (RULE14) Pins stay low until mix enables output
// (RULE15) Program uses scaling of three for IR
// (RULE16) Program issues mix right after preset
// (RULE17) All-zero mix stops buzzer output
// (RULE18) Reset gives tap zero, quarter duty, inactive
// (RULE19) Down-counter reloads N, output spans X pulses
// (RULE20) Buzzer is carrier AND OR-ed envelope; the code passes the carrier alone when no envelope tap is set
// (RULE21) New preset takes effect at next reload
//
// Purpose: Tone frequency generator with buzzer output stage, AHB-Lite slave
// Assumes: Single 20 MHz clock; port B and table data come from the same clock
// Notes:   Zero-wait-state slave; all outputs are registered
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module tfg_top
    import tfg_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RSTN,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // Table memory lookup for the indexed preset
    output logic [7:0]       INDEX_POINTER,
    input  wire logic [7:0]  TABLE_DATA,
    // Generator clock offered to alarm, timers and converter counter
    output logic             GENERATOR_OUTPUT,
    output logic             GENERATOR_TICK,
    // Shared port B pins
    input  wire logic        PORT_B_BIT_THREE,
    input  wire logic        PORT_B_BIT_FOUR,
    output logic             PIN_B3_OUT,
    output logic             PIN_B4_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Last phase index of an output period, i.e. X-1
    function automatic logic [1:0] duty_last(input tfg_duty_type d);
        case (d)
            DUTY_QUARTER: duty_last = 2'd3;
            DUTY_THIRD:   duty_last = 2'd2;
            DUTY_HALF:    duty_last = 2'd1;
            default:      duty_last = 2'd0;
        endcase
    endfunction : duty_last

    // Source-edge enable for the programmable divider
    function automatic logic src_pulse(input tfg_src_type s,
                                       input logic [TAP_COUNT-1:0] rise);
        case (s)
            SRC_PH0:  src_pulse = rise[0];
            SRC_PH1:  src_pulse = rise[1];
            SRC_PH2:  src_pulse = rise[2];
            default:  src_pulse = 1'b1;
        endcase
    endfunction : src_pulse

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge CLOCK or negedge RSTN)
    begin
        if (!RSTN)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // Pre-divider taps
    logic [TAP_COUNT-1:0] tap_level;
    logic [TAP_COUNT-1:0] tap_rise;

    tfg_prediv u_prediv (
        .clk       (CLOCK),
        .rst_n     (rst_n),
        .tap_level (tap_level),
        .tap_rise  (tap_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State
    tfg_top_state_type st;
    tfg_top_state_type nx;
    logic              wr;
    logic              src_en;
    logic              preset_hit;
    logic [7:0]        preset_n;
    tfg_duty_type      preset_duty;
    logic [1:0]        next_phase;
    logic              car_lvl;
    logic              env_ok;
    logic              bz_active;
    logic              reload;

    assign wr     = st.a_valid && st.a_write;
    assign src_en = src_pulse(st.src, tap_rise);                          // RULE6
    assign reload = (st.gen_state == GEN_RUN) && src_en && (st.dcnt == 8'h00);

    // Read word chosen in the address phase so HRDATA comes from a flop
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input tfg_top_state_type s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ADDR_CLK_SRC:    w[1:0] = s.src;
            ADDR_PRESET_REG,
            ADDR_PRESET_IMM:
            begin
                w[7:0]                = s.n_act;
                w[DUTY_LSB+1:DUTY_LSB] = s.duty_act;
            end
            ADDR_PRESET_IDX:
            begin
                w[7:0]                = s.idx_ptr;
                w[DUTY_LSB+1:DUTY_LSB] = s.idx_duty;
            end
            ADDR_BUZ_MIX:
            begin
                w[2:0]               = s.carrier;
                w[ENV_LSB+5:ENV_LSB] = s.env;
            end
            ADDR_PIN_CFG:    w[0] = s.pin_sel;
            ADDR_STATUS:
            begin
                w[7:0]                = s.n_act;
                w[DUTY_LSB+1:DUTY_LSB] = s.duty_act;
                w[ST_RUN_BIT]         = (s.gen_state == GEN_RUN);
                w[ST_GOUT_BIT]        = s.gout;
                w[ST_BZ_BIT]          = s.bz_t;
                w[ST_PEND_BIT]        = s.pend_valid;
            end
            default:         w = 32'h0000_0000;
        endcase
        read_word = w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        nx          = st;
        nx.gtick    = 1'b0;
        preset_hit  = 1'b0;
        preset_n    = RST_N;
        preset_duty = RST_DUTY;
        next_phase  = 2'd0;

        // Address phase capture; every transfer answers OKAY with no wait
        if (HSEL && HREADY && HTRANS[1])
        begin
            nx.a_valid = 1'b1;
            nx.a_write = HWRITE;
            nx.a_addr  = HADDR[7:0];
            nx.hrdata  = HWRITE ? 32'h0000_0000 : read_word(HADDR[7:0], st);
        end
        else if (HREADY)
        begin
            nx.a_valid = 1'b0;
        end

        // Table word arrives one cycle after the pointer went out
        if (st.idx_wait)
        begin
            preset_hit  = 1'b1;
            preset_n    = TABLE_DATA;                                     // RULE4
            preset_duty = st.idx_duty;
            nx.idx_wait = 1'b0;
        end

        // Data phase writes
        if (wr)
        begin
            case (st.a_addr)
                ADDR_CLK_SRC:    nx.src = tfg_src_type'(HWDATA[1:0]);     // RULE6
                ADDR_PRESET_REG:
                begin
                    preset_hit  = 1'b1;
                    preset_n    = {HWDATA[ACC_LSB+3:ACC_LSB], HWDATA[3:0]}; // RULE3
                    preset_duty = tfg_duty_type'(HWDATA[DUTY_LSB+1:DUTY_LSB]);
                end
                ADDR_PRESET_IDX:
                begin
                    nx.idx_ptr  = HWDATA[7:0];                            // RULE4
                    nx.idx_duty = tfg_duty_type'(HWDATA[DUTY_LSB+1:DUTY_LSB]);
                    nx.idx_wait = 1'b1;
                end
                ADDR_PRESET_IMM:
                begin
                    preset_hit  = 1'b1;
                    preset_n    = HWDATA[7:0];                            // RULE5
                    preset_duty = tfg_duty_type'(HWDATA[DUTY_LSB+1:DUTY_LSB]);
                end
                ADDR_BUZ_MIX:
                begin
                    nx.carrier = tfg_carrier_type'(HWDATA[2:0]);          // RULE13
                    nx.env     = HWDATA[ENV_LSB+5:ENV_LSB];               // RULE13
                end
                ADDR_PIN_CFG:    nx.pin_sel = HWDATA[0];                  // RULE10
                default:         ;
            endcase
        end

        // Programmable divider and duty sequencer
        case (st.gen_state)
            GEN_IDLE:
            begin
                if (preset_hit)
                begin
                    nx.gen_state  = GEN_RUN;                              // RULE7
                    nx.n_act      = preset_n;
                    nx.duty_act   = preset_duty;
                    nx.dcnt       = preset_n;
                    nx.phase      = 2'd0;
                    nx.gout       = 1'b1;
                    nx.pend_valid = 1'b0;
                end
            end
            GEN_RUN:
            begin
                if (reload)
                begin
                    // One pulse per N+1 source edges
                    nx.gtick = 1'b1;                                      // RULE19
                    if (st.pend_valid)
                    begin
                        // Pending preset only lands here, so no runt period
                        nx.n_act      = st.n_pend;                        // RULE21
                        nx.duty_act   = st.duty_pend;
                        nx.dcnt       = st.n_pend;
                        nx.pend_valid = 1'b0;
                        nx.phase      = 2'd0;
                        nx.gout       = 1'b1;
                    end
                    else
                    begin
                        nx.dcnt = st.n_act;                               // RULE19
                        if (st.phase >= duty_last(st.duty_act))
                            next_phase = 2'd0;
                        else
                            next_phase = st.phase + 2'd1;
                        nx.phase = next_phase;                            // RULE1
                        nx.gout  = (st.duty_act == DUTY_FULL) || (next_phase == 2'd0); // RULE2
                    end
                end
                else if (src_en)
                begin
                    nx.dcnt = st.dcnt - 8'h01;
                end
                // Set after the clear so a preset in the reload cycle is kept
                if (preset_hit)
                begin
                    nx.n_pend     = preset_n;                             // RULE21
                    nx.duty_pend  = preset_duty;
                    nx.pend_valid = 1'b1;
                end
            end
            default:
            begin
                nx.gen_state = GEN_IDLE;
            end
        endcase

        // Buzzer carrier: exactly one source, invalid codes act as off
        case (st.carrier)
            CAR_PH3:  car_lvl = tap_level[3];                             // RULE11
            CAR_PH4:  car_lvl = tap_level[4];
            CAR_PH5:  car_lvl = tap_level[5];
            CAR_GENERATOR_OUTPUT: car_lvl = st.gout;
            default:  car_lvl = 1'b0;
        endcase
        bz_active = (st.carrier == CAR_PH3) || (st.carrier == CAR_PH4) ||
                    (st.carrier == CAR_PH5) || (st.carrier == CAR_GENERATOR_OUTPUT);  // RULE17

        // Envelope gates the carrier; none selected means unmodulated
        env_ok = (st.env == 6'h00) ||
                 (|(st.env & tap_level[ENV_TAP_BASE+5:ENV_TAP_BASE]));    // RULE12

        nx.bz_t = bz_active && car_lvl && env_ok;                         // RULE20
        nx.bz_i = bz_active && !nx.bz_t;                                  // RULE9

        // Shared pins take the buzzer pair when configured
        nx.pin_b3 = st.pin_sel ? nx.bz_i : PORT_B_BIT_THREE;              // RULE10
        nx.pin_b4 = st.pin_sel ? nx.bz_t : PORT_B_BIT_FOUR;               // RULE10
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset leaves tap zero, quarter duty, output idle
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st           <= '0;
            st.src       <= RST_SRC;                                      // RULE18
            st.duty_act  <= RST_DUTY;                                     // RULE18
            st.n_act     <= RST_N;
            st.gen_state <= GEN_IDLE;
            st.carrier   <= CAR_OFF;                                      // RULE14
            st.hreadyout <= 1'b1;
        end
        else
        begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    assign HRDATA           = st.hrdata;
    assign HREADYOUT        = st.hreadyout;
    assign HRESP            = 1'b0 & st.hreadyout;
    assign INDEX_POINTER    = st.idx_ptr;
    assign GENERATOR_OUTPUT = st.gout;                                    // RULE8
    assign GENERATOR_TICK   = st.gtick;                                   // RULE8
    assign PIN_B3_OUT       = st.pin_b3;
    assign PIN_B4_OUT       = st.pin_b4;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_pins_complement: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE9
        $past(bz_active) |-> (st.bz_i == !st.bz_t))
        else $error("buzzer pins not complementary while active");

    chk_mix_off_low: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE17
        (st.carrier == CAR_OFF) [*2] |-> (!st.bz_t && !st.bz_i))
        else $error("buzzer pins not low with mix off");

    chk_imm_start: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE7
        (wr && st.a_addr == ADDR_PRESET_IMM && st.gen_state == GEN_IDLE && !st.idx_wait)
        |=> (st.gen_state == GEN_RUN) && (st.n_act == $past(HWDATA[7:0])) && st.gout)
        else $error("immediate preset did not start generator");

    chk_reg_nibbles: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE3
        (wr && st.a_addr == ADDR_PRESET_REG && st.gen_state == GEN_RUN)
        |=> st.pend_valid && (st.n_pend == {$past(HWDATA[7:4]), $past(HWDATA[3:0])}))
        else $error("register preset nibbles misplaced");

    chk_table_load: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE4
        (st.idx_wait && !wr && st.gen_state == GEN_IDLE)
        |=> (st.n_act == $past(TABLE_DATA)) && (st.gen_state == GEN_RUN))
        else $error("table word not loaded");

    chk_reload_value: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE19
        reload |=> st.gtick && (st.dcnt == ($past(st.pend_valid) ? $past(st.n_pend)
                                                                 : $past(st.n_act))))
        else $error("divider reload value wrong");

    chk_pend_hold: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE21
        (st.pend_valid && !reload) |=> st.pend_valid && $stable(st.n_act))
        else $error("preset applied before reload");

    chk_phase_bound: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE1
        (st.gen_state == GEN_RUN) |-> (st.phase <= duty_last(st.duty_act)))
        else $error("duty phase out of range");

    chk_full_high: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE2
        (reload && !st.pend_valid && st.duty_act == DUTY_FULL) |=> st.gout)
        else $error("full duty output dropped low");

    chk_idle_quiet: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE18
        (st.gen_state == GEN_IDLE) |-> (!st.gout && !st.gtick))
        else $error("idle generator output active");

    chk_pin_route: assert property (@(posedge CLOCK) disable iff (!rst_n) // RULE10
        st.pin_sel |=> (PIN_B4_OUT == st.bz_t) && (PIN_B3_OUT == st.bz_i))
        else $error("buzzer pair not routed to port B pins");

endmodule : tfg_top

// [tfg_buzzer_model.sv]
// Purpose: Buzzer load between the complementary pin pair
// Assumes: Pins sampled on the system clock edge
// Notes:   Counts drive pulses only; a buzzer has no way to push back
`timescale 1ns/1ps
module tfg_buzzer_model
(
    // Clock and pins
    input  wire logic clk,
    input  wire logic pin_true,
    input  wire logic pin_inv,
    // Pulse count seen by the load
    output int        rises
);
    logic last_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // Load is driven only while the pair is opposite, so equal pins give no pulse
    always @(posedge clk)
    begin
        if (pin_true && !pin_inv && !last_q) rises <= rises + 1;
        last_q <= pin_true && !pin_inv;
    end
endmodule : tfg_buzzer_model

// [tone_frequency_generator_buzzer_tb.sv]
// Purpose: Self-checking bench for the tone generator and buzzer stage
// Assumes: Base clock source for all but the last test so that periods are short and exact
// Notes:   Envelope taps run too slowly to reach in a short run
`timescale 1ns/1ps
module tone_frequency_generator_buzzer_tb;
    import tfg_pkg::*;
    logic CLOCK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd;
    logic [1:0] HTRANS = 2'h0;
    logic [7:0] INDEX_POINTER, TABLE_DATA = 8'h00;
    logic GENERATOR_OUTPUT, GENERATOR_TICK, PIN_B3_OUT, PIN_B4_OUT;
    logic PORT_B_BIT_THREE = 1'b0, PORT_B_BIT_FOUR = 1'b0;
    int fail_count = 0, n_tests = 0, seed = 32'he7e3, n, x, hi, tk, r0, rises;
    ////////////////////////////////////////////////////////////////////////////
    // Clock, device and buzzer load
    always #25 CLOCK = ~CLOCK;
    tfg_top uut (.CLOCK(CLOCK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .INDEX_POINTER(INDEX_POINTER),
        .TABLE_DATA(TABLE_DATA), .GENERATOR_OUTPUT(GENERATOR_OUTPUT),
        .GENERATOR_TICK(GENERATOR_TICK), .PORT_B_BIT_THREE(PORT_B_BIT_THREE),
        .PORT_B_BIT_FOUR(PORT_B_BIT_FOUR), .PIN_B3_OUT(PIN_B3_OUT), .PIN_B4_OUT(PIN_B4_OUT));
    tfg_buzzer_model load (.clk(CLOCK), .pin_true(PIN_B4_OUT), .pin_inv(PIN_B3_OUT),
        .rises(rises));
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("Checks %0d, errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One single transfer; a hung ready counts as a mismatch
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do begin @(posedge CLOCK); t++; end while (HREADYOUT !== 1'b1 && t < 40);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do begin @(posedge CLOCK); t++; end while (HREADYOUT !== 1'b1 && t < 40);
        rd = HRDATA;
        chk("hresp", 0, HRESP);
        if (t >= 40)
        begin
            fail_count++;
            end_sim();
        end
    endtask : bus
    task meas(input int w);
        hi = 0;
        tk = 0;
        repeat (w)
        begin
            @(posedge CLOCK);
            hi += (GENERATOR_OUTPUT === 1'b1);
            tk += (GENERATOR_TICK === 1'b1);
        end
    endtask : meas
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (16) @(posedge CLOCK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLOCK);
        chk("pins", 0, {PIN_B3_OUT, PIN_B4_OUT});
        bus(1'b0, ADDR_STATUS, 0);
        chk("status", 0, rd);
        bus(1'b0, 8'h1c, 0);
        chk("unmapped", 0, rd);
        bus(1'b1, ADDR_CLK_SRC, SRC_BASE);
        $display("Test reset done");
        for (int d = 0; d < 4; d++)
        begin
            n = 1 + ({$random(seed)} % 7);
            x = 4 - d;
            bus(1'b1, ADDR_PRESET_IMM, {22'h0, d[1:0], n[7:0]});
            repeat (20) @(posedge CLOCK);
            meas(4 * (n + 1) * x);
            chk("ticks", 4 * x, tk);
            chk("high", 4 * (n + 1), hi);
            bus(1'b0, ADDR_STATUS, 0);
            chk("preset", {d[1:0], n[7:0]}, rd[9:0]);
        end
        $display("Test duty done");
        n = $random(seed);
        bus(1'b1, ADDR_PRESET_REG, {22'h0, 2'b10, n[7:4], n[3:0]});
        repeat (20) @(posedge CLOCK);
        bus(1'b0, ADDR_PRESET_REG, 0);
        chk("reg form", {2'b10, n[7:0]}, rd[9:0]);
        r0 = $random(seed);
        TABLE_DATA <= r0[15:8];
        bus(1'b1, ADDR_PRESET_IDX, {22'h0, 2'b01, r0[7:0]});
        // Pointer is launched at the data-phase edge; look one edge later
        @(posedge CLOCK);
        chk("pointer", r0[7:0], INDEX_POINTER);
        repeat (300) @(posedge CLOCK);
        bus(1'b0, ADDR_STATUS, 0);
        chk("idx form", {2'b01, r0[15:8]}, rd[9:0]);
        $display("Test preset forms done");
        bus(1'b1, ADDR_PIN_CFG, 1);
        bus(1'b1, ADDR_PRESET_IMM, {22'h0, 2'b10, 8'h03});
        bus(1'b1, ADDR_BUZ_MIX, CAR_GENERATOR_OUTPUT);
        repeat (300) @(posedge CLOCK);
        r0 = rises;
        repeat (64)
        begin
            @(posedge CLOCK);
            chk("complement", !PIN_B4_OUT, PIN_B3_OUT);
        end
        chk("pulses", 8, rises - r0);
        // Tap three carrier: one rise per sixteen base ticks
        bus(1'b1, ADDR_BUZ_MIX, CAR_PH3);
        repeat (20) @(posedge CLOCK);
        r0 = rises;
        repeat (32 * PH_TICK_CYCLES) @(posedge CLOCK);
        chk("tap3 pulses", 2, rises - r0);
        bus(1'b1, ADDR_BUZ_MIX, 0);
        repeat (3) @(posedge CLOCK);
        chk("stopped", 0, {PIN_B3_OUT, PIN_B4_OUT});
        bus(1'b1, ADDR_PIN_CFG, 0);
        PORT_B_BIT_THREE <= 1'b1;
        PORT_B_BIT_FOUR <= r0[0];
        repeat (3) @(posedge CLOCK);
        chk("port b", {1'b1, r0[0]}, {PIN_B3_OUT, PIN_B4_OUT});
        $display("Test buzzer done");
        // Tap zero source: one divider edge per two base ticks, N=0 full duty
        bus(1'b1, ADDR_CLK_SRC, SRC_PH0);
        bus(1'b1, ADDR_PRESET_IMM, {22'h0, 2'b11, 8'h00});
        repeat (3000) @(posedge CLOCK);
        meas(8 * PH_TICK_CYCLES);
        chk("tap ticks", 4, tk);
        chk("tap high", 8 * PH_TICK_CYCLES, hi);
        $display("Test source done");
        end_sim();
    end
endmodule : tone_frequency_generator_buzzer_tb
